// ===== verilog/sensor_compensation_filter.v
// Sensor compensation, clamp and IIR datapath with AHB-Lite registers
//
// Implementation choices: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/100ps
`include "comp_consts.vh"
module sensor_compensation_filter (
  input  wire        clk,          // 250 MHz clock
  input  wire        rst_n,        // Synchronous reset, active low
  input  wire        hsel,         // AHB slave select
  input  wire [11:0] haddr,        // AHB address
  input  wire [1:0]  htrans,       // AHB transfer type
  input  wire        hwrite,       // AHB write
  input  wire [2:0]  hsize,        // AHB size
  input  wire        hready,       // AHB bus ready
  input  wire [31:0] hwdata,       // AHB write data
  output reg  [31:0] hrdata,       // AHB read data
  output reg         hreadyout,    // AHB slave ready
  output reg         hresp,        // AHB response, always OKAY
  input  wire [15:0] p_adc,        // Raw pressure sample
  input  wire        p_valid,      // Pressure sample strobe
  input  wire [15:0] t_adc,        // Raw temperature sample
  input  wire        t_valid,      // Temperature sample strobe
  output reg  [13:0] filtered_output, // Code for the output converter
  output reg         out_valid     // One-cycle update strobe
);
  localparam W = 40;
  localparam S_IDLE = 2'd0;
  localparam S_COMP = 2'd1;
  localparam S_FILT = 2'd2;
  localparam S_DONE = 2'd3;
  // ************************************************
  // Register storage
  // ************************************************
  reg [15:0] p_off_r;
  reg [15:0] p_gain_r;
  reg [15:0] t_off_r;
  reg [15:0] t_gain_r;
  reg [15:0] coef_r [0:15];
  reg [15:0] filt_r [0:5];
  reg [13:0] low_clamp_r;
  reg [13:0] high_clamp_r;
  reg [13:0] norm_low_r;
  reg [13:0] norm_high_r;
  reg [15:0] p_raw_r;
  reg [15:0] t_raw_r;
  reg [13:0] comp_r;
  reg signed [W-1:0] w1_r;
  reg signed [W-1:0] w2_r;
  reg signed [W-1:0] w0_r;
  reg [1:0]  state_r;
  reg        wr_pend_r;
  reg [11:0] wr_addr_r;
  integer    i;
  // ************************************************
  // Channel scaling and compensation polynomial
  // ************************************************
  wire signed [W-1:0] p_sum;
  wire signed [W-1:0] t_sum;
  wire signed [W-1:0] p_sc;
  wire signed [W-1:0] t_sc;
  wire signed [W-1:0] poly0;
  wire signed [W-1:0] poly1;
  wire signed [W-1:0] poly2;
  wire signed [W-1:0] poly3;
  wire signed [W-1:0] acc3;
  wire signed [W-1:0] acc2;
  wire signed [W-1:0] acc1;
  wire signed [W-1:0] dac_val;
  // Raw samples treated as unsigned, offsets signed
  assign p_sum = $signed({{(W-16){1'b0}}, p_raw_r})
               + $signed({{(W-16){p_off_r[15]}}, p_off_r});
  assign t_sum = $signed({{(W-16){1'b0}}, t_raw_r})
               + $signed({{(W-16){t_off_r[15]}}, t_off_r});
  // Digital gain, unity at 2^14
  fx_mul #(.AW(W), .BW(16), .OW(W), .SH(`COEF_FRAC)) pg
  (
    .a(p_sum), .b(p_gain_r), .y(p_sc)
  );
  fx_mul #(.AW(W), .BW(16), .OW(W), .SH(`COEF_FRAC)) tg
  (
    .a(t_sum), .b(t_gain_r), .y(t_sc)
  );
  // Four temperature cubics, coefficient groups h, g, n, m
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1)
    begin : poly
      wire signed [W-1:0] py;
      cubic_eval #(.W(W)) ce
      (
        .t(t_sc), .c0(coef_r[4*g]), .c1(coef_r[4*g+1]),
        .c2(coef_r[4*g+2]), .c3(coef_r[4*g+3]), .y(py)
      );
    end
  endgenerate
  assign poly0 = poly[0].py;
  assign poly1 = poly[1].py;
  assign poly2 = poly[2].py;
  assign poly3 = poly[3].py;
  // Horner in P: coefficients scaled by 2^14, P in whole codes
  wire signed [W-1:0] hp3;
  wire signed [W-1:0] hp2;
  wire signed [W-1:0] hp1;
  // Inner P factors use 2^-16 scale so P^3 stays bounded
  fx_mul #(.AW(W), .BW(W), .OW(W), .SH(16)) mp3 (.a(poly3), .b(p_sc), .y(hp3));
  assign acc3 = hp3 + poly2;
  fx_mul #(.AW(W), .BW(W), .OW(W), .SH(16)) mp2 (.a(acc3), .b(p_sc), .y(hp2));
  assign acc2 = hp2 + poly1;
  // Last stage uses 2^14 so g0 = 2^14 gives exactly P
  fx_mul #(.AW(W), .BW(W), .OW(W), .SH(`COEF_FRAC)) mp1 (.a(acc2), .b(p_sc), .y(hp1));
  assign acc1 = hp1 + {{(W-16){1'b0}}, 16'h0000};
  // Offset h0 is in 2^-14 units of output code
  wire signed [W-1:0] h0_q;
  assign h0_q = poly0 >>> `COEF_FRAC;
  // Final sum one bit wider, then saturated instead of wrapped
  wire signed [W:0]   dac_wide;
  assign dac_wide = {acc1[W-1], acc1} + {h0_q[W-1], h0_q};
  assign dac_val  = (dac_wide[W] != dac_wide[W-1]) ?
                    {dac_wide[W], {(W-1){~dac_wide[W]}}} : dac_wide[W-1:0];
  // ************************************************
  // Clamp
  // ************************************************
  reg [13:0] clamp_val;
  always @*
  begin
    if (dac_val < $signed({{(W-14){1'b0}}, low_clamp_r}))
      clamp_val = low_clamp_r;
    else if (dac_val > $signed({{(W-14){1'b0}}, high_clamp_r}))
      clamp_val = high_clamp_r;
    else
      clamp_val = dac_val[13:0];
  end
  // ************************************************
  // IIR filter
  // ************************************************
  wire signed [W-1:0] comp_w;
  wire signed [W-1:0] ta0;
  wire signed [W-1:0] ta1;
  wire signed [W-1:0] ta2;
  wire signed [W-1:0] tb0;
  wire signed [W-1:0] tb1;
  wire signed [W-1:0] tb2;
  wire signed [W-1:0] w_new;
  wire signed [W-1:0] y_f;
  assign comp_w = {{(W-14){1'b0}}, comp_r};
  fx_mul #(.AW(W), .BW(16), .OW(W), .SH(`COEF_FRAC)) fa0 (.a(comp_w), .b(filt_r[0]), .y(ta0));
  fx_mul #(.AW(W), .BW(16), .OW(W), .SH(`COEF_FRAC)) fa1 (.a(w1_r), .b(filt_r[1]), .y(ta1));
  fx_mul #(.AW(W), .BW(16), .OW(W), .SH(`COEF_FRAC)) fa2 (.a(w2_r), .b(filt_r[2]), .y(ta2));
  assign w_new = ta0 + ta1 + ta2;
  fx_mul #(.AW(W), .BW(16), .OW(W), .SH(`COEF_FRAC)) fb0 (.a(w0_r), .b(filt_r[3]), .y(tb0));
  fx_mul #(.AW(W), .BW(16), .OW(W), .SH(`COEF_FRAC)) fb1 (.a(w1_r), .b(filt_r[4]), .y(tb1));
  fx_mul #(.AW(W), .BW(16), .OW(W), .SH(`COEF_FRAC)) fb2 (.a(w2_r), .b(filt_r[5]), .y(tb2));
  assign y_f = tb0 + tb1 + tb2;
  // Saturate filter output to the 14-bit code range
  reg [13:0] y_code;
  always @*
  begin
    if (y_f < 0)
      y_code = 14'h0000;
    else if (y_f > $signed({{(W-14){1'b0}}, 14'h3fff}))
      y_code = 14'h3fff;
    else
      y_code = y_f[13:0];
  end
  // ************************************************
  // Update sequencer
  // ************************************************
  // Pressure sample starts one update; temperature just latched
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      state_r         <= S_IDLE;
      p_raw_r         <= 16'h0000;
      t_raw_r         <= 16'h0000;
      comp_r          <= 14'h0000;
      w0_r            <= {W{1'b0}};
      w1_r            <= {W{1'b0}};
      w2_r            <= {W{1'b0}};
      filtered_output <= 14'h0000;
      out_valid       <= 1'b0;
    end
    else
    begin
      out_valid <= 1'b0;
      if (t_valid)
        t_raw_r <= t_adc;
      case (state_r)
        S_IDLE:
        begin
          if (p_valid)
          begin
            p_raw_r <= p_adc;
            state_r <= S_COMP;
          end
        end
        S_COMP:
        begin
          comp_r  <= clamp_val;
          state_r <= S_FILT;
        end
        S_FILT:
        begin
          if (filt_r[0] == 16'h0000)
          begin
            filtered_output <= comp_r;
            state_r         <= S_IDLE;
            out_valid       <= 1'b1;
          end
          else
          begin
            w0_r    <= w_new;
            state_r <= S_DONE;
          end
        end
        S_DONE:
        begin
          // Output held until the next update
          filtered_output <= y_code;
          w2_r            <= w1_r;
          w1_r            <= w0_r;
          out_valid       <= 1'b1;
          state_r         <= S_IDLE;
        end
        default: state_r <= S_IDLE;
      endcase
    end
  end
  // ************************************************
  // AHB-Lite slave, zero wait states
  // ************************************************
  wire acc = hsel & hready & htrans[1];
  // Read right behind a write to the same register: the register only
  // updates at this edge, so the data phase word is forwarded instead
  reg        fwd_hit;
  reg [31:0] fwd_data;
  always @*
  begin
    fwd_hit  = 1'b0;
    fwd_data = 32'h00000000;
    if (wr_pend_r && wr_addr_r == haddr)
    begin
      case (haddr)
        `OFS_LOW_CLAMP, `OFS_HIGH_CLAMP, `OFS_NORM_LOW, `OFS_NORM_HIGH:
        begin
          fwd_hit  = 1'b1;
          fwd_data = {18'h00000, hwdata[13:0]};
        end
        `OFS_P_OFFSET, `OFS_P_GAIN, `OFS_T_OFFSET, `OFS_T_GAIN:
        begin
          fwd_hit  = 1'b1;
          fwd_data = {16'h0000, hwdata[15:0]};
        end
        default:
        begin
          if (haddr[11:6] == 6'h01 || (haddr[11:5] == 7'h05 && haddr[4:2] < 3'd6))
          begin
            fwd_hit  = 1'b1;
            fwd_data = {16'h0000, hwdata[15:0]};
          end
        end
      endcase
    end
  end
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      wr_pend_r    <= 1'b0;
      wr_addr_r    <= 12'h000;
      hreadyout    <= 1'b1;
      hresp        <= 1'b0;
      hrdata       <= 32'h00000000;
      p_off_r      <= 16'h0000;
      p_gain_r     <= `UNITY;
      t_off_r      <= 16'h0000;
      t_gain_r     <= `UNITY;
      low_clamp_r  <= `RST_LOW_CLAMP;
      high_clamp_r <= `RST_HIGH_CLAMP;
      norm_low_r   <= `RST_NORM_LOW;
      norm_high_r  <= `RST_NORM_HIGH;
      for (i = 0; i < 16; i = i + 1)
        coef_r[i] <= 16'h0000;
      for (i = 0; i < 6; i = i + 1)
        filt_r[i] <= 16'h0000;
    end
    else
    begin
      wr_pend_r <= acc & hwrite;
      wr_addr_r <= haddr;
      // Write data arrives in the data phase
      if (wr_pend_r)
      begin
        case (wr_addr_r)
          `OFS_P_OFFSET:   p_off_r      <= hwdata[15:0];
          `OFS_P_GAIN:     p_gain_r     <= hwdata[15:0];
          `OFS_T_OFFSET:   t_off_r      <= hwdata[15:0];
          `OFS_T_GAIN:     t_gain_r     <= hwdata[15:0];
          `OFS_LOW_CLAMP:  low_clamp_r  <= hwdata[13:0];
          `OFS_HIGH_CLAMP: high_clamp_r <= hwdata[13:0];
          `OFS_NORM_LOW:   norm_low_r   <= hwdata[13:0];
          `OFS_NORM_HIGH:  norm_high_r  <= hwdata[13:0];
          default:
          begin
            if (wr_addr_r[11:6] == 6'h01)
              coef_r[wr_addr_r[5:2]] <= hwdata[15:0];
            else if (wr_addr_r[11:5] == 7'h05 && wr_addr_r[4:2] < 3'd6)
              filt_r[wr_addr_r[4:2]] <= hwdata[15:0];
          end
        endcase
      end
      // Read data registered; unmapped reads give zero
      if (acc & ~hwrite)
      begin
        case (haddr)
          `OFS_P_OFFSET:   hrdata <= {16'h0000, p_off_r};
          `OFS_P_GAIN:     hrdata <= {16'h0000, p_gain_r};
          `OFS_T_OFFSET:   hrdata <= {16'h0000, t_off_r};
          `OFS_T_GAIN:     hrdata <= {16'h0000, t_gain_r};
          `OFS_LOW_CLAMP:  hrdata <= {18'h00000, low_clamp_r};
          `OFS_HIGH_CLAMP: hrdata <= {18'h00000, high_clamp_r};
          `OFS_NORM_LOW:   hrdata <= {18'h00000, norm_low_r};
          `OFS_NORM_HIGH:  hrdata <= {18'h00000, norm_high_r};
          `OFS_OUT:        hrdata <= {18'h00000, filtered_output};
          `OFS_TEMP:       hrdata <= {16'h0000, t_raw_r};
          `OFS_COMP:       hrdata <= {18'h00000, comp_r};
          default:
          begin
            if (haddr[11:6] == 6'h01)
              hrdata <= {16'h0000, coef_r[haddr[5:2]]};
            else if (haddr[11:5] == 7'h05 && haddr[4:2] < 3'd6)
              hrdata <= {16'h0000, filt_r[haddr[4:2]]};
            else
              hrdata <= 32'h00000000;
          end
        endcase
        // A write still in its data phase wins over the stored word
        if (fwd_hit)
          hrdata <= fwd_data;
      end
    end
  end
endmodule

// ===== verilog/comp_consts.vh
// Constants for the sensor compensation filter datapath
`ifndef COMP_CONSTS_VH
`define COMP_CONSTS_VH
// Register byte offsets on the AHB-Lite slave
`define OFS_P_OFFSET   12'h000
`define OFS_P_GAIN     12'h004
`define OFS_T_OFFSET   12'h008
`define OFS_T_GAIN     12'h00c
`define OFS_COEF_BASE  12'h040
`define OFS_LOW_CLAMP  12'h080
`define OFS_HIGH_CLAMP 12'h084
`define OFS_NORM_LOW   12'h088
`define OFS_NORM_HIGH  12'h08c
`define OFS_FILT_BASE  12'h0a0
`define OFS_OUT        12'h0c0
`define OFS_TEMP       12'h0c4
`define OFS_COMP       12'h0c8
// Fixed-point scale: unity is 2^14
`define COEF_FRAC      14
`define UNITY          16'h4000
// Reset values
`define RST_LOW_CLAMP  14'h0000
`define RST_HIGH_CLAMP 14'h3fff
`define RST_NORM_LOW   14'h0667
`define RST_NORM_HIGH  14'h399a
// Internal temperature sensor references at gain five
`define TADC_M40C      16'h16c9
`define TADC_0C        16'h1acf
`define TADC_150C      16'h29e5
`endif

// ===== verilog/fx_mul.v
// Signed fixed-point multiply with saturation to a Q-format result
`timescale 1ns/100ps
module fx_mul #(
  parameter AW = 32,
  parameter BW = 16,
  parameter OW = 32,
  parameter SH = 14
) (
  input  wire signed [AW-1:0] a,   // Multiplicand
  input  wire signed [BW-1:0] b,   // Coefficient
  output reg  signed [OW-1:0] y    // Saturated scaled product
);
  // Full-width product keeps every bit before shifting
  wire signed [AW+BW-1:0] prod;
  wire signed [AW+BW-1:0] shf;
  localparam signed [AW+BW-1:0] MAXV = {{(AW+BW-OW+1){1'b0}}, {(OW-1){1'b1}}};
  localparam signed [AW+BW-1:0] MINV = ~MAXV;
  assign prod = a * b;
  assign shf  = prod >>> SH;
  // Saturate instead of wrapping on overflow
  always @*
  begin
    if (shf > MAXV)
      y = MAXV[OW-1:0];
    else if (shf < MINV)
      y = MINV[OW-1:0];
    else
      y = shf[OW-1:0];
  end
endmodule

// ===== verilog/cubic_eval.v
// Cubic polynomial in temperature, Horner form, products saturated
`timescale 1ns/100ps
module cubic_eval #(
  parameter W = 32
) (
  input  wire signed [W-1:0]  t,    // Temperature operand
  input  wire signed [15:0]   c0,   // Constant term
  input  wire signed [15:0]   c1,   // Linear term
  input  wire signed [15:0]   c2,   // Quadratic term
  input  wire signed [15:0]   c3,   // Cubic term
  output wire signed [W-1:0]  y     // Result in coefficient units
);
  wire signed [W-1:0] s3;
  wire signed [W-1:0] s2;
  wire signed [W-1:0] s1;
  wire signed [W-1:0] k3;
  wire signed [W-1:0] k2;
  wire signed [W-1:0] k1;
  wire signed [W-1:0] k0;
  // Coefficients widened, still in units of 2^-14
  assign k3 = {{(W-16){c3[15]}}, c3};
  assign k2 = {{(W-16){c2[15]}}, c2};
  assign k1 = {{(W-16){c1[15]}}, c1};
  assign k0 = {{(W-16){c0[15]}}, c0};
  // Horner steps; T is a fraction of full scale in units of 2^-14
  fx_mul #(.AW(W), .BW(W), .OW(W), .SH(14)) m3 (.a(k3), .b(t), .y(s3));
  fx_mul #(.AW(W), .BW(W), .OW(W), .SH(14)) m2 (.a(s3 + k2), .b(t), .y(s2));
  fx_mul #(.AW(W), .BW(W), .OW(W), .SH(14)) m1 (.a(s2 + k1), .b(t), .y(s1));
  assign y = s1 + k0;
endmodule

// ===== sim/comp_chk.sv
// Port-level assertions for the compensation datapath
`timescale 1ns/100ps
module comp_chk (
  input wire        clk,             // Clock
  input wire        rst_n,           // Sync reset
  input wire        hsel,            // Slave select
  input wire [11:0] haddr,           // Address
  input wire [1:0]  htrans,          // Transfer type
  input wire        hwrite,          // Write
  input wire        hready,          // Bus ready
  input wire [31:0] hwdata,          // Write data
  input wire [31:0] hrdata,          // Read data
  input wire        hreadyout,       // Slave ready
  input wire        hresp,           // Response
  input wire        p_valid,         // Pressure strobe
  input wire [15:0] t_adc,           // Raw temperature
  input wire        t_valid,         // Temperature strobe
  input wire [13:0] filtered_output, // Output code
  input wire        out_valid        // Output strobe
);
  // ********************
  // Shadows and checks
  // ********************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  reg  [15:0] t_r;
  reg  [15:0] a0_r;
  reg  [13:0] lo_r;
  reg  [13:0] hi_r;
  reg  [11:0] wa_r;
  reg         wp_r;
  wire        take = hsel && hready && htrans[1];
  // Shadow what software wrote, so limits are judged without peeking inside
  always @(posedge clk)
  begin
    wp_r <= rst_n && take && hwrite;
    wa_r <= haddr;
    if (!rst_n)
    begin
      t_r  <= 16'h0000;
      a0_r <= 16'h0000;
      lo_r <= 14'h0000;
      hi_r <= 14'h3fff;
    end
    else
    begin
      if (t_valid) t_r <= t_adc;
      if (wp_r && wa_r == 12'h0a0) a0_r <= hwdata[15:0];
      if (wp_r && wa_r == 12'h080) lo_r <= hwdata[13:0];
      if (wp_r && wa_r == 12'h084) hi_r <= hwdata[13:0];
    end
  end
  AST_HOLD: assert property (!out_valid |-> $stable(filtered_output))
    else $error("output changed without strobe");
  AST_GAP: assert property (out_valid |=> !out_valid [*3])
    else $error("output strobes too close");
  AST_LAT_BYP: assert property ((out_valid && a0_r == 16'h0000) |-> $past(p_valid, 3))
    else $error("bypass latency wrong");
  AST_LAT_FILT: assert property ((out_valid && a0_r != 16'h0000) |-> $past(p_valid, 4))
    else $error("filtered latency wrong");
  AST_CLAMP: assert property ((out_valid && a0_r == 16'h0000) |->
    filtered_output >= lo_r && filtered_output <= hi_r)
    else $error("output outside clamp limits");
  AST_TEMP_RD: assert property ((take && !hwrite && haddr == 12'h0c4) |=>
    hrdata == {16'h0000, $past(t_r)})
    else $error("temperature read wrong");
  AST_UNMAPPED: assert property ((take && !hwrite && haddr == 12'h0fc) |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  AST_BUS_OK: assert property (hreadyout && !hresp)
    else $error("bus wait or error response");
endmodule

// ===== sim/adc_model.sv
// Sample source model for the pressure and temperature channels
`timescale 1ns/100ps
module adc_model (
  input  wire         clk,     // Clock
  output logic [15:0] p_adc,   // Raw pressure
  output logic        p_valid, // Pressure strobe
  output logic [15:0] t_adc,   // Raw temperature
  output logic        t_valid  // Temperature strobe
);
  // ********************
  // Channel drivers
  // ********************
  // Idle lines start low
  initial
  begin
    p_adc = 16'h0000;
    p_valid = 1'b0;
    t_adc = 16'h0000;
    t_valid = 1'b0;
  end
  // One pressure sample; stale data inverted so nobody can rely on it
  task automatic send_p(input logic [15:0] v);
    begin
      p_adc <= v;
      p_valid <= 1'b1;
      @(posedge clk);
      p_valid <= 1'b0;
      p_adc <= ~v;
    end
  endtask
  // One temperature sample, same line discipline
  task automatic send_t(input logic [15:0] v);
    begin
      t_adc <= v;
      t_valid <= 1'b1;
      @(posedge clk);
      t_valid <= 1'b0;
      t_adc <= ~v;
    end
  endtask
endmodule

// ===== sim/tb.sv
// Testbench for the compensation datapath
`timescale 1ns/100ps
`include "comp_consts.vh"
module tb;
  // ********************
  // Stimulus and checks
  // ********************
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        hsel = 1'b0;
  logic [11:0] haddr = 12'h000;
  logic [1:0]  htrans = 2'b00;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] rd;
  wire  [31:0] hrdata;
  wire         hreadyout, hresp, p_valid, t_valid, out_valid;
  wire  [15:0] p_adc, t_adc;
  wire  [13:0] filtered_output;
  int          miscompares = 0;
  int          checks_done = 0;
  // Clock, 4 ns period
  always #2 clk = ~clk;
  // Single slave, so its ready is the bus ready
  sensor_compensation_filter u_sensor_compensation_filter (
    .clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'b010), .hready(hreadyout), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .p_adc(p_adc),
    .p_valid(p_valid), .t_adc(t_adc), .t_valid(t_valid),
    .filtered_output(filtered_output), .out_valid(out_valid));
  adc_model u_adc_model (.clk(clk), .p_adc(p_adc), .p_valid(p_valid), .t_adc(t_adc),
    .t_valid(t_valid));
  // Compare and count
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    begin
      checks_done++;
      if (g !== e)
      begin
        miscompares++;
        $display("[FAIL] %s expected %h seen %h", s, e, g);
      end
    end
  endtask
  // One AHB-Lite transfer; each phase held until ready is sampled high
  task automatic ahb(input logic w, input logic [11:0] a, input logic [31:0] d);
    begin
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= 2'b10;
      @(posedge clk);
      while (hreadyout !== 1'b1) @(posedge clk);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      @(posedge clk);
      while (hreadyout !== 1'b1) @(posedge clk);
      rd = hrdata;
    end
  endtask
  task automatic rdc(input string s, input logic [11:0] a, input logic [31:0] e);
    begin
      ahb(1'b0, a, 32'h0);
      chk(s, e, rd);
    end
  endtask
  // Send a sample, count edges to the strobe; bounded so a hang is seen
  task automatic samp(input logic [15:0] p, input logic [13:0] e, input int lat);
    int n;
    begin
      n = 0;
      u_adc_model.send_p(p);
      do
      begin
        @(posedge clk);
        n++;
      end
      while (out_valid !== 1'b1 && n < 20);
      chk("latency", lat, n);
      chk("code", {18'h0, e}, {18'h0, filtered_output});
    end
  endtask
  task automatic t_reset;
    begin
      rdc("norm_low", `OFS_NORM_LOW, `RST_NORM_LOW);
      rdc("norm_high", `OFS_NORM_HIGH, `RST_NORM_HIGH);
      rdc("high_clamp", `OFS_HIGH_CLAMP, `RST_HIGH_CLAMP);
      rdc("p_gain", `OFS_P_GAIN, `UNITY);
      rdc("a0", `OFS_FILT_BASE, 32'h0);
      rdc("unmapped", 12'h0fc, 32'h0);
      $display("test reset values done");
    end
  endtask
  // All sixteen coefficient slots hold distinct values
  task automatic t_coef;
    begin
      for (int k = 0; k < 16; k++) ahb(1, 12'(`OFS_COEF_BASE + 4 * k), 32'h0100 + k);
      for (int k = 0; k < 16; k++) rdc("coef", 12'(`OFS_COEF_BASE + 4 * k), 32'h0100 + k);
      for (int k = 0; k < 16; k++) ahb(1, 12'(`OFS_COEF_BASE + 4 * k), 32'h0);
      ahb(1, `OFS_COEF_BASE + 12'h010, `UNITY);
      $display("test coefficients done");
    end
  endtask
  // Plain offset plus gain path ignores temperature
  task automatic t_pass;
    logic [15:0] tv[3];
    begin
      tv = '{`TADC_M40C, `TADC_0C, `TADC_150C};
      samp(16'h1234, 14'h1234, 3);
      for (int i = 0; i < 3; i++)
      begin
        u_adc_model.send_t(tv[i]);
        samp(16'h0abc, 14'h0abc, 3);
        rdc("temp", `OFS_TEMP, tv[i]);
      end
      $display("test passthrough done");
    end
  endtask
  task automatic t_gain;
    begin
      ahb(1, `OFS_P_GAIN, 32'h2000);
      samp(16'h2468, 14'h1234, 3);
      ahb(1, `OFS_P_GAIN, `UNITY);
      ahb(1, `OFS_P_OFFSET, 32'h0010);
      samp(16'h1000, 14'h1010, 3);
      ahb(1, `OFS_P_OFFSET, 32'h0);
      ahb(1, `OFS_COEF_BASE + 12'h010, 32'h2000);
      samp(16'h2000, 14'h1000, 3);
      ahb(1, `OFS_COEF_BASE + 12'h010, `UNITY);
      ahb(1, `OFS_COEF_BASE, 32'h4000);
      samp(16'h1000, 14'h1001, 3);
      ahb(1, `OFS_COEF_BASE, 32'h0);
      // n0 at unity adds P squared over 2^16
      ahb(1, `OFS_COEF_BASE + 12'h020, 32'h4000);
      samp(16'h0100, 14'h0101, 3);
      ahb(1, `OFS_COEF_BASE + 12'h020, 32'h0);
      // g1 at unity with T left at the 150 C code: (1 + T/2^14) * P
      ahb(1, `OFS_COEF_BASE + 12'h014, 32'h4000);
      samp(16'h0100, 14'h01a7, 3);
      ahb(1, `OFS_COEF_BASE + 12'h014, 32'h0);
      $display("test gain offset done");
    end
  endtask
  // Low limit kept above the loop's own supply current
  task automatic t_clamp;
    begin
      ahb(1, `OFS_LOW_CLAMP, 32'h0200);
      samp(16'h0100, 14'h0200, 3);
      ahb(1, `OFS_HIGH_CLAMP, 32'h3000);
      samp(16'h3800, 14'h3000, 3);
      rdc("comp", `OFS_COMP, 32'h3000);
      ahb(1, `OFS_LOW_CLAMP, 32'h0);
      ahb(1, `OFS_HIGH_CLAMP, `RST_HIGH_CLAMP);
      samp(16'hffff, 14'h3fff, 3);
      ahb(1, `OFS_P_GAIN, 32'h7fff);
      samp(16'hffff, 14'h3fff, 3);
      ahb(1, `OFS_P_GAIN, `UNITY);
      $display("test clamp done");
    end
  endtask
  // b1 alone delays by one sample; a0 zero bypasses
  task automatic t_filter;
    begin
      ahb(1, `OFS_FILT_BASE, `UNITY);
      ahb(1, `OFS_FILT_BASE + 12'h00c, `UNITY);
      samp(16'h0800, 14'h0800, 4);
      ahb(1, `OFS_FILT_BASE + 12'h00c, 32'h0);
      ahb(1, `OFS_FILT_BASE + 12'h010, `UNITY);
      samp(16'h0a00, 14'h0800, 4);
      ahb(1, `OFS_FILT_BASE, 32'h0);
      samp(16'h0123, 14'h0123, 3);
      $display("test filter done");
    end
  endtask
  // Write then read one register back to back; the read sees the new word
  task automatic t_b2b;
    begin
      hsel <= 1'b1;
      htrans <= 2'b10;
      hwrite <= 1'b1;
      haddr <= `OFS_NORM_LOW;
      @(posedge clk);
      while (hreadyout !== 1'b1) @(posedge clk);
      hwrite <= 1'b0;
      hwdata <= 32'h1555;
      @(posedge clk);
      while (hreadyout !== 1'b1) @(posedge clk);
      hsel <= 1'b0;
      htrans <= 2'b00;
      @(posedge clk);
      while (hreadyout !== 1'b1) @(posedge clk);
      chk("b2b", 32'h1555, hrdata);
      $display("test back to back done");
    end
  endtask
  task automatic end_of_test;
    begin
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask
  // Main sequence after three reset cycles
  initial
  begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_b2b();
    t_coef();
    t_pass();
    t_gain();
    t_clamp();
    t_filter();
    end_of_test();
  end
  // Watchdog, far beyond the few hundred cycles needed
  initial
  begin
    #80000;
    miscompares++;
    end_of_test();
  end
endmodule
bind sensor_compensation_filter comp_chk u_comp_chk (.clk(clk), .rst_n(rst_n), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hwdata(hwdata),
  .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .p_valid(p_valid), .t_adc(t_adc),
  .t_valid(t_valid), .filtered_output(filtered_output), .out_valid(out_valid));
